// *** src/dsfb_pkg.sv ***
package dsfb_pkg;

    // two-wire device select, 7-bit form of the diagnostic page address
    localparam logic [6:0]  DEV_ADDR       = 7'h51;

    // byte map of the diagnostic page
    localparam logic [7:0]  OFS_THR_LO     = 8'h00;
    localparam logic [7:0]  OFS_CHECKSUM   = 8'h5F;
    localparam logic [7:0]  OFS_RT_LO      = 8'h60;
    localparam logic [7:0]  OFS_RT_HI      = 8'h69;
    localparam logic [7:0]  OFS_STATUS     = 8'h6E;
    localparam logic [7:0]  OFS_ALARM_A    = 8'h70;
    localparam logic [7:0]  OFS_ALARM_B    = 8'h71;
    localparam logic [7:0]  OFS_WARN_A     = 8'h74;
    localparam logic [7:0]  OFS_WARN_B     = 8'h75;
    localparam logic [7:0]  OFS_USER_LO    = 8'h80;
    localparam logic [7:0]  OFS_USER_HI    = 8'hF7;

    // fixed image: thresholds, calibration constants, checksum
    localparam int          ROM_BYTES      = 96;
    localparam int          THR_BYTES      = 40;
    localparam int          CHK_BYTES      = 95;
    localparam int          USER_BYTES     = 120;
    localparam int          NUM_QTY        = 5;
    localparam int          QTY_STRIDE     = 8;
    localparam int          CAL_SLOPE_0    = 76;
    localparam int          CAL_SLOPE_1    = 80;
    localparam int          CAL_SLOPE_2    = 84;
    localparam int          CAL_SLOPE_3    = 88;
    localparam logic [7:0]  CAL_SLOPE_MSB  = 8'h01;

    // threshold defaults
    localparam logic [15:0] THR_HI_SIGNED  = 16'h7FFF;
    localparam logic [15:0] THR_LO_SIGNED  = 16'h8000;
    localparam logic [15:0] THR_HI_UNSIGN  = 16'hFFFF;
    localparam logic [15:0] THR_LO_UNSIGN  = 16'h0000;

    // status/control bit positions
    localparam int          BIT_TXDIS_PIN  = 7;
    localparam int          BIT_SOFT_TXDIS = 6;
    localparam int          BIT_FAULT      = 2;
    localparam int          BIT_SIGDET     = 1;
    localparam int          BIT_READY_N    = 0;
    localparam int          BIT_FLAG_B_HI  = 7;
    localparam int          BIT_FLAG_B_LO  = 6;

    // timing
    localparam longint      CLK_HZ         = 200_000_000;
    localparam longint      MS_PER_S       = 1000;
    localparam longint      READY_TIME_MS  = 1000;
    localparam longint      READY_CYCLES_L = READY_TIME_MS * CLK_HZ / MS_PER_S;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_DEVADDR = 4'h1,
        ST_ACK_DEV = 4'h2,
        ST_WORD    = 4'h3,
        ST_ACK_WRD = 4'h4,
        ST_WRDATA  = 4'h5,
        ST_ACK_WR  = 4'h6,
        ST_RDDATA  = 4'h7,
        ST_RD_ACK  = 4'h8
    } dsfb_state_t;

    // per quantity: high alarm, low alarm, high warning, low warning, msb first
    function automatic logic [THR_BYTES*8-1:0] dsfb_thresh_default();
        logic [THR_BYTES*8-1:0] v;
        logic [15:0]            hi;
        logic [15:0]            lo;
        v = '0;
        for (int q = 0; q < NUM_QTY; q++) begin
            hi = (q == 0) ? THR_HI_SIGNED : THR_HI_UNSIGN;
            lo = (q == 0) ? THR_LO_SIGNED : THR_LO_UNSIGN;
            v[(q*QTY_STRIDE+0)*8 +: 8] = hi[15:8];
            v[(q*QTY_STRIDE+1)*8 +: 8] = hi[7:0];
            v[(q*QTY_STRIDE+2)*8 +: 8] = lo[15:8];
            v[(q*QTY_STRIDE+3)*8 +: 8] = lo[7:0];
            v[(q*QTY_STRIDE+4)*8 +: 8] = hi[15:8];
            v[(q*QTY_STRIDE+5)*8 +: 8] = hi[7:0];
            v[(q*QTY_STRIDE+6)*8 +: 8] = lo[15:8];
            v[(q*QTY_STRIDE+7)*8 +: 8] = lo[7:0];
        end
        return v;
    endfunction : dsfb_thresh_default

    // thresholds, calibration defaults and checksum over bytes 0..94
    function automatic logic [ROM_BYTES*8-1:0] dsfb_build_rom(
        input logic [THR_BYTES*8-1:0] thr
    );
        logic [ROM_BYTES*8-1:0] v;
        logic [7:0]             sum;
        v = '0;
        sum = '0;
        v[THR_BYTES*8-1:0] = thr;
        v[CAL_SLOPE_0*8 +: 8] = CAL_SLOPE_MSB;
        v[CAL_SLOPE_1*8 +: 8] = CAL_SLOPE_MSB;
        v[CAL_SLOPE_2*8 +: 8] = CAL_SLOPE_MSB;
        v[CAL_SLOPE_3*8 +: 8] = CAL_SLOPE_MSB;
        for (int i = 0; i < CHK_BYTES; i++) begin
            sum = sum + v[i*8 +: 8];
        end
        v[CHK_BYTES*8 +: 8] = sum;
        return v;
    endfunction : dsfb_build_rom

endpackage : dsfb_pkg

// *** src/dsfb_bank.sv ***
`timescale 1ns/100ps
module dsfb_bank #(
    parameter int unsigned                              READY_CYCLES =
        int'(dsfb_pkg::READY_CYCLES_L),
    parameter logic [dsfb_pkg::THR_BYTES*8-1:0]         THRESH_INIT  =
        dsfb_pkg::dsfb_thresh_default()
) (
    // clocks and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        meas_clk_i,
    // two-wire serial bus
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // module pins
    input  wire logic        tx_disable_i,
    input  wire logic        laser_fault_i,
    input  wire logic        sig_det_i,
    output logic             tx_disable_o,
    // measurements, meas_clk_i domain
    input  wire logic        meas_valid_i,
    output logic             meas_ready_o,
    input  wire logic [15:0] meas_temp_i,
    input  wire logic [15:0] meas_vcc_i,
    input  wire logic [15:0] meas_bias_i,
    input  wire logic [15:0] meas_txpwr_i,
    input  wire logic [15:0] meas_rxpwr_i
);

    localparam logic [dsfb_pkg::ROM_BYTES*8-1:0] ROM_IMG =
        dsfb_pkg::dsfb_build_rom(THRESH_INIT);

    // high/low compare, temperature signed
    function automatic logic dsfb_over(
        input int          q,
        input logic [15:0] v,
        input logic [15:0] t
    );
        if (q == 0) begin
            return $signed(v) > $signed(t);
        end
        return v > t;
    endfunction : dsfb_over

    function automatic logic [15:0] dsfb_thr(input int q, input int k);
        return {ROM_IMG[(q*dsfb_pkg::QTY_STRIDE+2*k)*8 +: 8],
                ROM_IMG[(q*dsfb_pkg::QTY_STRIDE+2*k+1)*8 +: 8]};
    endfunction : dsfb_thr

    // ---------------- measurement side (meas_clk_i) ----------------
    logic [15:0] hold [dsfb_pkg::NUM_QTY];
    logic        req_tgl;
    logic        ack_m1;
    logic        ack_m2;
    logic        ack_tgl;

    assign meas_ready_o = (req_tgl == ack_m2);

    always_ff @(posedge meas_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_m1  <= 1'b0;
            ack_m2  <= 1'b0;
            req_tgl <= 1'b0;
            for (int q = 0; q < dsfb_pkg::NUM_QTY; q++) begin
                hold[q] <= '0;
            end
        end else begin
            ack_m1 <= ack_tgl;
            ack_m2 <= ack_m1;
            if (meas_valid_i && meas_ready_o) begin
                hold[0] <= meas_temp_i;
                hold[1] <= meas_vcc_i;
                hold[2] <= meas_bias_i;
                hold[3] <= meas_txpwr_i;
                hold[4] <= meas_rxpwr_i;
                req_tgl <= ~req_tgl;
            end
        end
    end

    // ---------------- crossing into ref_clk_i ----------------
    logic req_s1;
    logic req_s2;
    logic req_s3;
    wire  new_meas = req_s2 ^ req_s3;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            req_s3  <= 1'b0;
            ack_tgl <= 1'b0;
        end else begin
            req_s1  <= req_tgl;
            req_s2  <= req_s1;
            req_s3  <= req_s2;
            ack_tgl <= req_s3;
        end
    end

    // ---------------- flag comparison ----------------
    logic [dsfb_pkg::NUM_QTY-1:0] hi_alm;
    logic [dsfb_pkg::NUM_QTY-1:0] lo_alm;
    logic [dsfb_pkg::NUM_QTY-1:0] hi_wrn;
    logic [dsfb_pkg::NUM_QTY-1:0] lo_wrn;
    logic [7:0]                   next_alarm_a;
    logic [7:0]                   next_warn_a;

    for (genvar q = 0; q < dsfb_pkg::NUM_QTY; q++) begin : g_cmp
        assign hi_alm[q] = dsfb_over(q, hold[q], dsfb_thr(q, 0));
        assign lo_alm[q] = dsfb_over(q, dsfb_thr(q, 1), hold[q]);
        assign hi_wrn[q] = dsfb_over(q, hold[q], dsfb_thr(q, 2));
        assign lo_wrn[q] = dsfb_over(q, dsfb_thr(q, 3), hold[q]);
    end

    for (genvar q = 0; q < dsfb_pkg::NUM_QTY - 1; q++) begin : g_pack
        assign next_alarm_a[7-2*q] = hi_alm[q];
        assign next_alarm_a[6-2*q] = lo_alm[q];
        assign next_warn_a[7-2*q]  = hi_wrn[q];
        assign next_warn_a[6-2*q]  = lo_wrn[q];
    end

    wire [7:0] next_alarm_b = {hi_alm[dsfb_pkg::NUM_QTY-1],
                               lo_alm[dsfb_pkg::NUM_QTY-1], 6'h00};
    wire [7:0] next_warn_b  = {hi_wrn[dsfb_pkg::NUM_QTY-1],
                               lo_wrn[dsfb_pkg::NUM_QTY-1], 6'h00};

    logic [15:0] rt [dsfb_pkg::NUM_QTY];
    logic [7:0]  alarm_flags_a;
    logic [7:0]  alarm_flags_b;
    logic [7:0]  warning_flags_a;
    logic [7:0]  warning_flags_b;
    logic        got_sample;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_flags_a   <= '0;
            alarm_flags_b   <= '0;
            warning_flags_a <= '0;
            warning_flags_b <= '0;
            got_sample      <= 1'b0;
            for (int q = 0; q < dsfb_pkg::NUM_QTY; q++) begin
                rt[q] <= '0;
            end
        end else if (new_meas) begin
            alarm_flags_a   <= next_alarm_a;
            alarm_flags_b   <= next_alarm_b;
            warning_flags_a <= next_warn_a;
            warning_flags_b <= next_warn_b;
            got_sample      <= 1'b1;
            for (int q = 0; q < dsfb_pkg::NUM_QTY; q++) begin
                rt[q] <= hold[q];
            end
        end
    end

    // ---------------- pins and data ready ----------------
    logic [2:0]  pin_s1;
    logic [2:0]  pin_s2;
    logic        soft_txdis;
    logic [31:0] ready_cnt;
    logic        ready_n;
    wire         ready_timeout = (ready_cnt >= READY_CYCLES);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1       <= '0;
            pin_s2       <= '0;
            ready_cnt    <= '0;
            ready_n      <= 1'b1;
            tx_disable_o <= 1'b0;
        end else begin
            pin_s1       <= {tx_disable_i, laser_fault_i, sig_det_i};
            pin_s2       <= pin_s1;
            ready_cnt    <= ready_timeout ? ready_cnt : ready_cnt + 32'h1;
            ready_n      <= ~(got_sample | ready_timeout);
            tx_disable_o <= soft_txdis | pin_s2[2];
        end
    end

    logic [7:0] soft_command_status;
    always_comb begin
        soft_command_status                           = 8'h00;
        soft_command_status[dsfb_pkg::BIT_TXDIS_PIN]  = pin_s2[2];
        soft_command_status[dsfb_pkg::BIT_SOFT_TXDIS] = soft_txdis;
        soft_command_status[dsfb_pkg::BIT_FAULT]      = pin_s2[1];
        soft_command_status[dsfb_pkg::BIT_SIGDET]     = pin_s2[0];
        soft_command_status[dsfb_pkg::BIT_READY_N]    = ready_n;
    end

    // ---------------- two-wire slave ----------------
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_s3;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_s3;
    dsfb_pkg::dsfb_state_t state;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic [7:0]        txb;
    logic [7:0]        ptr;
    logic              rw;
    logic              nack;
    logic [7:0]        user_mem [dsfb_pkg::USER_BYTES];

    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;
    wire start_c  = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    wire stop_c   = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
    wire byte_end = (bit_cnt == 4'h8);
    wire shifting = (state == dsfb_pkg::ST_DEVADDR) || (state == dsfb_pkg::ST_WORD) ||
                    (state == dsfb_pkg::ST_WRDATA);

    // read decode
    wire        in_rom  = (ptr < dsfb_pkg::OFS_RT_LO);
    wire        in_rt   = (ptr >= dsfb_pkg::OFS_RT_LO) && (ptr <= dsfb_pkg::OFS_RT_HI);
    wire        in_user = (ptr >= dsfb_pkg::OFS_USER_LO) && (ptr <= dsfb_pkg::OFS_USER_HI);
    wire [7:0]  rt_off  = ptr - dsfb_pkg::OFS_RT_LO;
    wire [7:0]  u_off   = ptr - dsfb_pkg::OFS_USER_LO;
    wire [15:0] rt_word = rt[rt_off[3:1]];
    wire [7:0]  rt_byte = rt_off[0] ? rt_word[7:0] : rt_word[15:8];
    wire [7:0]  rom_byte = ROM_IMG[ptr[6:0]*8 +: 8];
    wire [7:0]  rd_byte =
        in_rom  ? rom_byte :
        in_rt   ? rt_byte :
        in_user ? user_mem[u_off[6:0]] :
        (ptr == dsfb_pkg::OFS_STATUS)  ? soft_command_status :
        (ptr == dsfb_pkg::OFS_ALARM_A) ? alarm_flags_a :
        (ptr == dsfb_pkg::OFS_ALARM_B) ? alarm_flags_b :
        (ptr == dsfb_pkg::OFS_WARN_A)  ? warning_flags_a :
        (ptr == dsfb_pkg::OFS_WARN_B)  ? warning_flags_b : 8'h00;

    wire wr_byte   = (state == dsfb_pkg::ST_WRDATA) && scl_fall && byte_end;
    wire wr_user   = wr_byte && in_user;
    wire wr_status = wr_byte && (ptr == dsfb_pkg::OFS_STATUS);

    assign sda_o = 1'b0;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    // writable area and soft control
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            soft_txdis <= 1'b0;
            for (int i = 0; i < dsfb_pkg::USER_BYTES; i++) begin
                user_mem[i] <= '0;
            end
        end else begin
            if (wr_status) begin
                soft_txdis <= shreg[dsfb_pkg::BIT_SOFT_TXDIS];
            end
            if (wr_user) begin
                user_mem[u_off[6:0]] <= shreg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= dsfb_pkg::ST_IDLE;
            bit_cnt  <= '0;
            shreg    <= '0;
            txb      <= '0;
            ptr      <= '0;
            rw       <= 1'b0;
            nack     <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_c) begin
            state    <= dsfb_pkg::ST_DEVADDR;
            bit_cnt  <= '0;
            sda_oe_o <= 1'b0;
        end else if (stop_c) begin
            state    <= dsfb_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (scl_rise) begin
            if (shifting || state == dsfb_pkg::ST_RDDATA) begin
                shreg   <= {shreg[6:0], sda_s2};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (state == dsfb_pkg::ST_RD_ACK) begin
                nack <= sda_s2;
            end
        end else if (scl_fall) begin
            case (state)
                dsfb_pkg::ST_DEVADDR: begin
                    if (byte_end) begin
                        if (shreg[7:1] == dsfb_pkg::DEV_ADDR) begin
                            state    <= dsfb_pkg::ST_ACK_DEV;
                            rw       <= shreg[0];
                            sda_oe_o <= 1'b1;
                        end else begin
                            state <= dsfb_pkg::ST_IDLE;
                        end
                    end
                end
                dsfb_pkg::ST_ACK_DEV: begin
                    bit_cnt <= '0;
                    if (rw) begin
                        state    <= dsfb_pkg::ST_RDDATA;
                        txb      <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                    end else begin
                        state    <= dsfb_pkg::ST_WORD;
                        sda_oe_o <= 1'b0;
                    end
                end
                dsfb_pkg::ST_WORD: begin
                    if (byte_end) begin
                        ptr      <= shreg;
                        state    <= dsfb_pkg::ST_ACK_WRD;
                        sda_oe_o <= 1'b1;
                    end
                end
                dsfb_pkg::ST_WRDATA: begin
                    if (byte_end) begin
                        ptr      <= ptr + 8'h01;
                        state    <= dsfb_pkg::ST_ACK_WR;
                        sda_oe_o <= 1'b1;
                    end
                end
                dsfb_pkg::ST_ACK_WRD, dsfb_pkg::ST_ACK_WR: begin
                    bit_cnt  <= '0;
                    state    <= dsfb_pkg::ST_WRDATA;
                    sda_oe_o <= 1'b0;
                end
                dsfb_pkg::ST_RDDATA: begin
                    if (byte_end) begin
                        ptr      <= ptr + 8'h01;
                        state    <= dsfb_pkg::ST_RD_ACK;
                        sda_oe_o <= 1'b0;
                    end else begin
                        sda_oe_o <= ~txb[3'h7 - bit_cnt[2:0]];
                    end
                end
                dsfb_pkg::ST_RD_ACK: begin
                    bit_cnt <= '0;
                    if (nack) begin
                        state    <= dsfb_pkg::ST_IDLE;
                        sda_oe_o <= 1'b0;
                    end else begin
                        state    <= dsfb_pkg::ST_RDDATA;
                        txb      <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                    end
                end
                default: begin
                    state    <= dsfb_pkg::ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

endmodule : dsfb_bank

// *** testbench/dsfb_bank_properties.sv ***
`timescale 1ns/100ps
module dsfb_bank_properties (
    // clocks and reset
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic meas_clk_i,
    // watched ports
    input  wire logic scl_i,
    input  wire logic sda_o,
    input  wire logic sda_oe_o,
    input  wire logic tx_disable_i,
    input  wire logic tx_disable_o,
    input  wire logic meas_valid_i,
    input  wire logic meas_ready_o
);
    sequence s_take;
        meas_valid_i && meas_ready_o;
    endsequence
    a_take_drops_ready: assert property (@(posedge meas_clk_i) disable iff (!nrst_i)
        s_take |=> !meas_ready_o) else $error("ready stayed high after a take");
    a_ready_returns: assert property (@(posedge meas_clk_i) disable iff (!nrst_i)
        $fell(meas_ready_o) |-> ##[1:12] meas_ready_o) else $error("ready never came back");
    a_ready_low_span: assert property (@(posedge meas_clk_i) disable iff (!nrst_i)
        $fell(meas_ready_o) |-> !meas_ready_o [*2]) else $error("ready low too briefly");
    a_idle_ready_holds: assert property (@(posedge meas_clk_i) disable iff (!nrst_i)
        meas_ready_o && !meas_valid_i |=> meas_ready_o) else $error("ready dropped unasked");
    a_pin_forces_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        tx_disable_i [*4] |=> tx_disable_o) else $error("transmitter on with pin set");
    a_oe_on_scl_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2)) else $error("sda moved, scl high");
    a_ack_stands: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(sda_oe_o) |=> sda_oe_o [*8]) else $error("sda drive too short");
    a_open_drain: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        sda_o == 1'b0) else $error("sda drive value not low");
endmodule : dsfb_bank_properties
bind dsfb_bank dsfb_bank_properties u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .meas_clk_i(meas_clk_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .tx_disable_i(tx_disable_i), .tx_disable_o(tx_disable_o),
    .meas_valid_i(meas_valid_i), .meas_ready_o(meas_ready_o));

// *** testbench/dsfb_host_model.sv ***
`timescale 1ns/100ps
module dsfb_host_model (
    // clock
    input  wire logic ref_clk_i,
    // two-wire bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic hp();
        repeat (16) @(negedge ref_clk_i);
    endtask : hp
    task automatic start();
        sda_pull_o = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        sda_pull_o = 1'b1;
        hp();
        scl_o = 1'b0;
        hp();
    endtask : start
    task automatic stop();
        sda_pull_o = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        sda_pull_o = 1'b0;
        hp();
    endtask : stop
    task automatic bit_io(input logic v, output logic s);
        sda_pull_o = ~v;
        hp();
        scl_o = 1'b1;
        hp();
        s = sda_i;
        scl_o = 1'b0;
        repeat (4) @(negedge ref_clk_i);
    endtask : bit_io
    // eight bits msb first, then the ninth with the line released
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'b1, ack);
    endtask : xfer
endmodule : dsfb_host_model

// *** testbench/tb_diag_status_flag_bank.sv ***
`timescale 1ns/100ps
module tb_diag_status_flag_bank;
    localparam logic [319:0] THR = {5{64'h0002_0008_0001_0010}};
    localparam logic [7:0]   CHK = 8'(8'h05 * (8'h10 + 8'h01 + 8'h08 + 8'h02) + 8'h04);
    localparam logic [79:0]  SMP = 80'hF000_0050_0900_0180_1800;
    logic        ref_clk_i = 1'b0;
    logic        meas_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        tx_pin = 1'b1;
    logic        fault = 1'b1;
    logic        sdet = 1'b0;
    logic        mvalid = 1'b0;
    logic [79:0] mv = '0;
    logic        scl, pull, sda, oe, sdo, txoff, mready, ack;
    logic [7:0]  rb;
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    initial begin
        #3;
        forever #40 meas_clk_i = ~meas_clk_i;
    end
    assign sda = (oe ? sdo : 1'b1) & ~pull;
    dsfb_bank #(.READY_CYCLES(4000), .THRESH_INIT(THR)) dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .meas_clk_i(meas_clk_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
        .tx_disable_i(tx_pin), .laser_fault_i(fault), .sig_det_i(sdet),
        .tx_disable_o(txoff), .meas_valid_i(mvalid), .meas_ready_o(mready),
        .meas_temp_i(mv[79:64]), .meas_vcc_i(mv[63:48]), .meas_bias_i(mv[47:32]),
        .meas_txpwr_i(mv[31:16]), .meas_rxpwr_i(mv[15:0]));
    dsfb_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check1
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        host.start();
        host.xfer(8'hA2, rb, ack);
        check1(ack, 1'b0);
        host.xfer(ptr, rb, ack);
        check1(ack, 1'b0);
        host.xfer(d, rb, ack);
        check1(ack, 1'b0);
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        host.start();
        host.xfer(8'hA2, rb, ack);
        host.xfer(ptr, rb, ack);
        host.start();
        host.xfer(8'hA3, rb, ack);
        host.xfer(8'hFF, rb, ack);
        host.stop();
        check8(rb, exp);
    endtask : rd
    // burst read: host acks the first byte, pointer steps to the next
    task automatic rd2(input logic [7:0] ptr, input logic [15:0] exp);
        logic [15:0] d;
        host.start();
        host.xfer(8'hA2, rb, ack);
        host.xfer(ptr, rb, ack);
        host.start();
        host.xfer(8'hA3, rb, ack);
        for (int i = 15; i >= 8; i--) host.bit_io(1'b1, d[i]);
        host.bit_io(1'b0, ack);
        host.xfer(8'hFF, d[7:0], ack);
        host.stop();
        check8(d[15:8], exp[15:8]);
        check8(d[7:0], exp[7:0]);
    endtask : rd2
    // offer one sample, hold it until taken, then scramble the released data
    task automatic meas(input logic [79:0] s);
        @(negedge meas_clk_i);
        mv = s;
        mvalid = 1'b1;
        for (int i = 0; i < 20 && !mready; i++) @(negedge meas_clk_i);
        @(negedge meas_clk_i);
        mvalid = 1'b0;
        mv = ~s;
    endtask : meas
    task automatic final_report();
        $display("comparisons %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        rd(8'h6E, 8'h85);
        check1(txoff, 1'b1);
        tx_pin = 1'b0;
        fault = 1'b0;
        sdet = 1'b1;
        repeat (2000) @(negedge ref_clk_i);
        rd(8'h6E, 8'h02);
        wr(8'h6E, 8'h40);
        repeat (4) @(negedge ref_clk_i);
        check1(txoff, 1'b1);
        rd(8'h6E, 8'h42);
        wr(8'h6E, 8'h00);
        repeat (4) @(negedge ref_clk_i);
        check1(txoff, 1'b0);
        host.start();
        host.xfer(8'hA6, rb, ack);
        host.stop();
        check1(ack, 1'b1);
        wr(8'h80, 8'hA5);
        wr(8'hF7, 8'h5A);
        rd(8'h80, 8'hA5);
        rd(8'hF7, 8'h5A);
        wr(8'h5F, 8'h00);
        rd(8'h5F, CHK);
        rd(8'h4C, 8'h01);
        rd(8'h00, 8'h10);
        meas(SMP);
        for (int i = 0; i < 5; i++) begin
            rd(8'(96 + 2 * i), SMP[79 - 16 * i -: 8]);
            rd(8'(97 + 2 * i), SMP[71 - 16 * i -: 8]);
        end
        rd2(8'h68, SMP[15:0]);
        rd(8'h70, 8'h50);
        rd(8'h71, 8'h80);
        rd(8'h74, 8'h59);
        rd(8'h75, 8'h80);
        meas(80'h0400_0400_0400_0400_0400);
        rd(8'h70, 8'h00);
        rd(8'h75, 8'h00);
        final_report();
    end
endmodule : tb_diag_status_flag_bank
